/* src/dcdma_top.sv */
// top: channel sequencing, request sensing and bus cycle generation
module dcdma_top (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic XFER_REQUEST_CH0_N,
    input wire logic XFER_REQUEST_CH1_N,
    input wire logic EXTERNAL_MASTER_REQUEST_N,
    input wire logic NMI_N,
    input wire logic WAIT_N,
    input wire logic SERIAL_RX_FULL_FLAG0,
    input wire logic SERIAL_RX_FULL_FLAG1,
    input wire logic SERIAL_TX_EMPTY_FLAG0,
    input wire logic SERIAL_TX_EMPTY_FLAG1,
    input wire logic SERIAL_CLOCK1_DISABLE,
    input wire logic [7:0] DMA_WAIT_CONTROL_WR,
    input wire logic WAIT_CONTROL_WE,
    input wire logic [3:0] CHANNEL0_MODE_WR,
    input wire logic MODE_WE,
    input wire logic [7:0] STATUS_WR,
    input wire logic STATUS_WE,
    input wire logic [19:0] SOURCE_ADDRESS_CH0,
    input wire logic [19:0] DESTINATION_ADDRESS_CH0,
    input wire logic [15:0] BYTE_COUNT_CH0_WR,
    input wire logic COUNT0_WE,
    input wire logic [19:0] MEMORY_ADDRESS_CH1,
    input wire logic [15:0] IO_ADDRESS_CH1,
    input wire logic [15:0] BYTE_COUNT_CH1_WR,
    input wire logic COUNT1_WE,
    input wire logic [7:0] BUS_DATA_IN,
    input wire logic BUS_READY,
    output logic [19:0] BUS_ADDR,
    output logic [7:0] BUS_DATA_OUT,
    output logic BUS_WRITE,
    output logic MEMORY_REQUEST_STROBE_N,
    output logic IO_REQUEST_STROBE_N,
    output logic TRANSFER_END_CH0_N,
    output logic TRANSFER_END_CH1_N,
    output logic EXTERNAL_MASTER_GRANT_N,
    output logic DMA_OWNS_BUS,
    output logic TERMINATION_IRQ,
    output logic [7:0] DMA_STATUS_RD,
    output logic [15:0] BYTE_COUNT_CH0,
    output logic [15:0] BYTE_COUNT_CH1
);
    typedef enum logic [2:0] {IDLE, READ, WRITE, HOLD} dcdma_state_t;

    // pin synchronisers: stage 1 feeds only stage 2
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic req0_prev_q, req1_prev_q, nmi_prev_q;
    always_ff @(posedge CLOCK)
    begin
        sync1_q <= {NMI_N, EXTERNAL_MASTER_REQUEST_N,
                    XFER_REQUEST_CH1_N, XFER_REQUEST_CH0_N};
        sync2_q <= sync1_q;
        req0_prev_q <= sync2_q[0];
        req1_prev_q <= sync2_q[1];
        nmi_prev_q <= sync2_q[3];
    end
    wire pin_req0_n = sync2_q[0];
    wire pin_req1_n = sync2_q[1];
    wire ext_req_n = sync2_q[2];
    wire nmi_fall = nmi_prev_q & ~sync2_q[3];

    // control registers, cleared by reset except the byte counts and the address regs loaded from ports
    logic [7:0] wctl_q;
    logic [3:0] mode_q;
    logic de0_q, de1_q, channel0_irq_enable_q, channel1_irq_enable_q, dme_q;
    logic [15:0] cnt0_q, cnt1_q;
    logic [19:0] sa_q, da_q, ma_q;
    dcdma_state_t st_q;
    logic chan_q, ended_q, grant_q;
    logic [7:0] data_q;
    logic [1:0] waits_q;
    logic edge0_q, edge1_q;
    logic [19:0] prev_addr_q;
    logic [19:0] cur_addr;

    wire sense0_edge = wctl_q[dcdma_pkg::SENSE_CH0_BIT];
    wire sense1_edge = wctl_q[dcdma_pkg::SENSE_CH1_BIT];
    // mode: bits 3:2 destination kind, 1:0 source kind; 2'h2 means io
    wire src_io = mode_q[1:0] == 2'h2;
    wire dst_io = mode_q[3:2] == 2'h2;
    wire mem2mem = ~src_io & ~dst_io;
    wire [1:0] ssel = SOURCE_ADDRESS_CH0[dcdma_pkg::SEL_LO +: 2];
    wire [1:0] dsel = DESTINATION_ADDRESS_CH0[dcdma_pkg::SEL_LO +: 2];
    wire ser_req = (ssel == dcdma_pkg::SEL_SER0 & SERIAL_RX_FULL_FLAG0) |
                   (ssel == dcdma_pkg::SEL_SER1 & SERIAL_RX_FULL_FLAG1) |
                   (dsel == dcdma_pkg::SEL_SER0 & SERIAL_TX_EMPTY_FLAG0) |
                   (dsel == dcdma_pkg::SEL_SER1 & SERIAL_TX_EMPTY_FLAG1);
    wire use_pin0 = ssel == dcdma_pkg::SEL_PIN & dsel == dcdma_pkg::SEL_PIN;
    // pin acts as request whenever both channel 0 address select fields are SEL_PIN
    wire req0_n = use_pin0 ? pin_req0_n : ~ser_req;
    logic req0_d_prev_q;
    wire fall0 = req0_d_prev_q & ~req0_n;
    wire fall1 = req1_prev_q & ~pin_req1_n;

    wire want0 = de0_q & dme_q & (mem2mem | (sense0_edge ? edge0_q : ~req0_n));
    wire want1 = de1_q & dme_q & (sense1_edge ? edge1_q : ~pin_req1_n);
    // channel 0 first, but no preemption
    wire pick1 = ~want0 & want1;
    // external master wins at access boundary
    wire ext_wins = ~ext_req_n;

    // addresses for current access
    // channel 1: direction bit low reads memory and writes io
    wire rd_io = chan_q ? wctl_q[1] : src_io;
    wire wr_io = chan_q ? ~wctl_q[1] : dst_io;
    always_comb
    begin
        cur_addr = 20'h00000;
        if (chan_q)
            cur_addr = (st_q == READ) == wctl_q[1] ?
                       {4'h0, IO_ADDRESS_CH1} : ma_q;
        else
            cur_addr = (st_q == READ) ? sa_q : da_q;
    end
    wire cur_io = (st_q == READ) ? rd_io : wr_io;
    // 64kb crossing: bit 16 changes between accesses
    wire crossing = cur_addr[dcdma_pkg::CARRY_BIT] !=
                    prev_addr_q[dcdma_pkg::CARRY_BIT];
    wire cnt_last = chan_q ? cnt1_q == 16'h0001 : cnt0_q == 16'h0001;

    // enable write only with guard low
    wire wr_de0 = STATUS_WE & ~STATUS_WR[6] & STATUS_WR[7];
    wire wr_de1 = STATUS_WE & ~STATUS_WR[5] & STATUS_WR[4];

    // main sequencer; address bumps by mode (up only keeps it small)
    always_ff @(posedge CLOCK)
    begin
        req0_d_prev_q <= req0_n;
        if (COUNT0_WE)
            cnt0_q <= BYTE_COUNT_CH0_WR;
        if (COUNT1_WE)
            cnt1_q <= BYTE_COUNT_CH1_WR;
        if (RST)
        begin
            wctl_q <= dcdma_pkg::WAIT_CTRL_RST;
            mode_q <= 4'h0;
            de0_q <= 1'b0; de1_q <= 1'b0;
            channel0_irq_enable_q <= 1'b0; channel1_irq_enable_q <= 1'b0;
            dme_q <= 1'b0;
            st_q <= IDLE;
            chan_q <= 1'b0;
            ended_q <= 1'b0;
            grant_q <= 1'b0;
            waits_q <= 2'h0;
            edge0_q <= 1'b0; edge1_q <= 1'b0;
            prev_addr_q <= 20'h00000;
            data_q <= 8'h00;
        end
        else
        begin
            if (WAIT_CONTROL_WE)
                wctl_q <= DMA_WAIT_CONTROL_WR;
            if (MODE_WE)
                mode_q <= CHANNEL0_MODE_WR;
            if (STATUS_WE)
            begin
                channel0_irq_enable_q <= STATUS_WR[2];
                channel1_irq_enable_q <= STATUS_WR[1];
                dme_q <= STATUS_WR[0];
            end
            // enable write reloads addresses or resumes
            if (wr_de0)
            begin
                de0_q <= 1'b1;
                dme_q <= 1'b1;
                // a still-enabled channel resumes where it was suspended
                if (!de0_q)
                begin
                    sa_q <= SOURCE_ADDRESS_CH0;
                    da_q <= DESTINATION_ADDRESS_CH0;
                end
            end
            if (wr_de1)
            begin
                de1_q <= 1'b1;
                dme_q <= 1'b1;
                if (!de1_q)
                    ma_q <= MEMORY_ADDRESS_CH1;
            end
            // nmi clears master enable; the clear beats a same-cycle write
            if (nmi_fall)
                dme_q <= 1'b0;
            if (fall0)
                edge0_q <= 1'b1;
            if (fall1)
                edge1_q <= 1'b1;
            unique case (st_q)
                IDLE:
                begin
                    grant_q <= ext_wins;
                    if (!ext_wins && (want0 || want1))
                    begin
                        chan_q <= pick1;
                        st_q <= READ;
                        waits_q <= 2'h0;
                        if (!pick1 && !fall0)
                            edge0_q <= 1'b0;
                        if (pick1 && !fall1)
                            edge1_q <= 1'b0;
                    end
                end
                READ, WRITE:
                begin
                    if (waits_q == 2'h0 && (cur_io || crossing))
                        waits_q <= cur_io ? dcdma_pkg::IO_AUTO_WAITS :
                                   dcdma_pkg::BOUNDARY_IDLES;
                    if (waits_q != 2'h0)
                        waits_q <= waits_q - 2'h1;
                    if (waits_q == 2'h1 || (waits_q == 2'h0 && !cur_io &&
                        !crossing))
                        if (BUS_READY && WAIT_N)
                        begin
                            prev_addr_q <= cur_addr;
                            waits_q <= 2'h0;
                            if (st_q == READ)
                            begin
                                data_q <= BUS_DATA_IN;
                                st_q <= ext_wins ? HOLD : WRITE;
                            end
                            else
                            begin
                                if (chan_q)
                                begin
                                    cnt1_q <= cnt1_q - 16'h0001;
                                    ma_q <= ma_q + 20'h00001;
                                end
                                else
                                begin
                                    cnt0_q <= cnt0_q - 16'h0001;
                                    if (!src_io)
                                        sa_q <= sa_q + 20'h00001;
                                    if (!dst_io)
                                        da_q <= da_q + 20'h00001;
                                end
                                if (cnt_last && chan_q)
                                    de1_q <= 1'b0;
                                if (cnt_last && !chan_q)
                                    de0_q <= 1'b0;
                                st_q <= IDLE;
                            end
                        end
                end
                HOLD:
                begin
                    // resume write after external master leaves
                    grant_q <= ext_wins;
                    if (!ext_wins)
                        st_q <= WRITE;
                end
                default:
                    st_q <= IDLE;
            endcase
        end
    end

    // bus outputs; strobes low only during dma access
    wire active = st_q == READ || st_q == WRITE;
    assign MEMORY_REQUEST_STROBE_N = ~(active & ~cur_io);
    assign IO_REQUEST_STROBE_N = ~(active & cur_io);
    assign BUS_ADDR = active ? cur_addr : 20'h00000;
    assign BUS_DATA_OUT = data_q;
    assign BUS_WRITE = st_q == WRITE;
    // end strobe with last write; channel 0 only while shared pin enabled
    assign TRANSFER_END_CH0_N = ~(st_q == WRITE & ~chan_q & cnt_last &
                                  SERIAL_CLOCK1_DISABLE);
    assign TRANSFER_END_CH1_N = ~(st_q == WRITE & chan_q & cnt_last);
    assign EXTERNAL_MASTER_GRANT_N = ~grant_q;
    assign DMA_OWNS_BUS = st_q != IDLE && st_q != HOLD;
    assign TERMINATION_IRQ = (~de0_q & channel0_irq_enable_q) | (~de1_q & channel1_irq_enable_q);
    // same layout as the status write; guard bits read 0
    assign DMA_STATUS_RD = {de0_q, 2'h0, de1_q, 1'b0, channel0_irq_enable_q, channel1_irq_enable_q, dme_q};
    assign BYTE_COUNT_CH0 = cnt0_q;
    assign BYTE_COUNT_CH1 = cnt1_q;
endmodule

/* src/dcdma_pkg.sv */
// package: constants and carrier types for the two-channel dma sequencer
package dcdma_pkg;
    // request source select, address bits 17:16 of channel 0
    localparam logic [1:0] SEL_PIN = 2'h0;
    localparam logic [1:0] SEL_SER0 = 2'h1;
    localparam logic [1:0] SEL_SER1 = 2'h2;
    // field positions
    localparam int SEL_LO = 16;
    localparam int CARRY_BIT = 16;
    localparam int SENSE_CH0_BIT = 3;
    localparam int SENSE_CH1_BIT = 2;
    // reset values
    localparam logic [7:0] WAIT_CTRL_RST = 8'h00;
    // timing: automatic io wait states, boundary idle states
    localparam logic [1:0] IO_AUTO_WAITS = 2'h1;
    localparam logic [1:0] BOUNDARY_IDLES = 2'h1;
    localparam logic [7:0] IO_ADDR_HI_ZERO = 8'h00;
    // access kind of one bus cycle
    typedef enum logic [1:0] {DCD_MEM, DCD_MMIO, DCD_IO} dcdma_space_t;
    // one bus access request and its attributes
    typedef struct packed {
        logic [19:0] addr;
        logic [7:0] data;
        logic write;
        logic last;
        logic chan;
        dcdma_space_t space;
    } dcdma_acc_t;
endpackage

/* verification/dcdma_props.sv */
// checker: port timing relations of the dma sequencer
module dcdma_props (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic NMI_N,
    input wire logic STATUS_WE,
    input wire logic [7:0] STATUS_WR,
    input wire logic BUS_WRITE,
    input wire logic MEMORY_REQUEST_STROBE_N,
    input wire logic IO_REQUEST_STROBE_N,
    input wire logic TRANSFER_END_CH0_N,
    input wire logic TRANSFER_END_CH1_N,
    input wire logic EXTERNAL_MASTER_GRANT_N,
    input wire logic TERMINATION_IRQ,
    input wire logic [7:0] DMA_STATUS_RD
);
    wire logic mrq_n = MEMORY_REQUEST_STROBE_N;
    wire logic io_request_strobe_n_n = IO_REQUEST_STROBE_N;
    wire logic [7:0] st = DMA_STATUS_RD;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    // one strobe at a time, none while the external master owns the bus
    property p_one_strobe; mrq_n || io_request_strobe_n_n; endproperty
    a_one_strobe: assert property (p_one_strobe)
        else $error("both strobes low");
    property p_grant_quiet; !EXTERNAL_MASTER_GRANT_N |-> mrq_n && io_request_strobe_n_n;
    endproperty
    a_grant_quiet: assert property (p_grant_quiet)
        else $error("strobe driven while bus granted away");
    // release of reset leaves an idle bus and cleared enables
    property p_reset_idle;
        $fell(RST) |-> mrq_n && io_request_strobe_n_n && EXTERNAL_MASTER_GRANT_N
            && !st[7] && !st[4] && !st[0];
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("not idle after reset");
    // end pulses only ride on write cycles
    property p_end0; !TRANSFER_END_CH0_N |-> BUS_WRITE; endproperty
    a_end0: assert property (p_end0)
        else $error("channel 0 end outside a write");
    property p_end1; !TRANSFER_END_CH1_N |-> BUS_WRITE; endproperty
    a_end1: assert property (p_end1)
        else $error("channel 1 end outside a write");
    // io access can never finish in its first cycle
    property p_io_wait; $fell(io_request_strobe_n_n) |=> !io_request_strobe_n_n; endproperty
    a_io_wait: assert property (p_io_wait)
        else $error("io access without automatic wait");
    property p_irq_level;
        (!st[7] && st[2]) || (!st[4] && st[1]) |-> ##[0:1] TERMINATION_IRQ;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("termination request missing");
    property p_nmi_abort; $fell(NMI_N) |-> ##[1:6] !st[0]; endproperty
    a_nmi_abort: assert property (p_nmi_abort)
        else $error("master enable survived nmi");
    property p_guard; STATUS_WE && STATUS_WR[6] && !st[7] |=> !st[7];
    endproperty
    a_guard: assert property (p_guard)
        else $error("enable set with guard high");
    cover property (!TRANSFER_END_CH0_N);
    cover property (!EXTERNAL_MASTER_GRANT_N);
    cover property ($fell(NMI_N));
endmodule
bind dcdma_top dcdma_props dcdma_props_inst (.CLOCK, .RST, .NMI_N,
    .STATUS_WE, .STATUS_WR, .BUS_WRITE, .MEMORY_REQUEST_STROBE_N,
    .IO_REQUEST_STROBE_N, .TRANSFER_END_CH0_N, .TRANSFER_END_CH1_N,
    .EXTERNAL_MASTER_GRANT_N, .TERMINATION_IRQ, .DMA_STATUS_RD);

/* verification/dcdma_bus_partner.sv */
// partner: memory and io responder with random stalls
module dcdma_bus_partner (
    input wire logic CLOCK,
    input wire logic slow,
    input wire logic [19:0] BUS_ADDR,
    input wire logic BUS_WRITE,
    input wire logic MEMORY_REQUEST_STROBE_N,
    input wire logic IO_REQUEST_STROBE_N,
    output logic BUS_READY,
    output logic [7:0] BUS_DATA_IN
);
    timeunit 1ns;
    timeprecision 100ps;
    int n_q = 0;
    int lim_q = 0;
    logic [7:0] last_q = 8'h00;
    wire logic act = !(MEMORY_REQUEST_STROBE_N && IO_REQUEST_STROBE_N);
    always @(posedge CLOCK)
    begin
        n_q <= act ? n_q + 1 : 0;
        if (!act)
            lim_q <= slow ? $urandom_range(3) : 0;
    end
    assign BUS_READY = act && n_q >= lim_q;
    // released data lines show the inverse, never a stale copy
    always @(posedge CLOCK)
        if (act && !BUS_WRITE)
            last_q <= BUS_DATA_IN;
    assign BUS_DATA_IN = act && !BUS_WRITE ? BUS_ADDR[7:0] ^ 8'ha5 : ~last_q;
endmodule

/* verification/testbench.sv */
// testbench: queue model of byte moves against the dma sequencer
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic CLOCK, RST, XFER_REQUEST_CH0_N, XFER_REQUEST_CH1_N, NMI_N, WAIT_N;
    logic EXTERNAL_MASTER_REQUEST_N, BUS_READY, SERIAL_CLOCK1_DISABLE;
    logic SERIAL_RX_FULL_FLAG0, SERIAL_RX_FULL_FLAG1;
    logic SERIAL_TX_EMPTY_FLAG0, SERIAL_TX_EMPTY_FLAG1, BUS_WRITE;
    logic WAIT_CONTROL_WE, MODE_WE, STATUS_WE, COUNT0_WE, COUNT1_WE;
    logic [7:0] DMA_WAIT_CONTROL_WR, STATUS_WR, BUS_DATA_IN, BUS_DATA_OUT;
    logic [7:0] DMA_STATUS_RD;
    logic [3:0] CHANNEL0_MODE_WR;
    logic [19:0] SOURCE_ADDRESS_CH0, DESTINATION_ADDRESS_CH0;
    logic [19:0] MEMORY_ADDRESS_CH1, BUS_ADDR, base;
    logic [15:0] IO_ADDRESS_CH1, BYTE_COUNT_CH0_WR, BYTE_COUNT_CH1_WR;
    logic [15:0] BYTE_COUNT_CH0, BYTE_COUNT_CH1, hold;
    logic MEMORY_REQUEST_STROBE_N, IO_REQUEST_STROBE_N, TRANSFER_END_CH0_N;
    logic TRANSFER_END_CH1_N, EXTERNAL_MASTER_GRANT_N, DMA_OWNS_BUS;
    logic TERMINATION_IRQ, req_n, slow, src_mem, pend;
    logic [22:0] cur, prv = '1;
    logic [7:0] pdo;
    logic [7:0] q[$];
    int ch, sel, n_exp, nbytes, nread, n_mismatch, checks;
    assign WAIT_N = 1'b1;
    assign SERIAL_TX_EMPTY_FLAG0 = 1'b0;
    assign SERIAL_TX_EMPTY_FLAG1 = 1'b0;
    assign SERIAL_CLOCK1_DISABLE = 1'b1;
    // flags idle low until the request toggles
    assign XFER_REQUEST_CH0_N = ch == 0 && sel == 0 ? req_n : 1'b1;
    assign XFER_REQUEST_CH1_N = ch == 1 ? req_n : 1'b1;
    assign SERIAL_RX_FULL_FLAG0 = sel == 1 && !req_n;
    assign SERIAL_RX_FULL_FLAG1 = sel == 2 && !req_n;
    dcdma_top dcdma_top_inst (.CLOCK, .RST, .XFER_REQUEST_CH0_N,
        .XFER_REQUEST_CH1_N, .EXTERNAL_MASTER_REQUEST_N, .NMI_N, .WAIT_N,
        .SERIAL_RX_FULL_FLAG0, .SERIAL_RX_FULL_FLAG1, .SERIAL_TX_EMPTY_FLAG0,
        .SERIAL_TX_EMPTY_FLAG1, .SERIAL_CLOCK1_DISABLE, .DMA_WAIT_CONTROL_WR,
        .WAIT_CONTROL_WE, .CHANNEL0_MODE_WR, .MODE_WE, .STATUS_WR, .STATUS_WE,
        .SOURCE_ADDRESS_CH0, .DESTINATION_ADDRESS_CH0, .BYTE_COUNT_CH0_WR,
        .COUNT0_WE, .MEMORY_ADDRESS_CH1, .IO_ADDRESS_CH1, .BYTE_COUNT_CH1_WR,
        .COUNT1_WE, .BUS_DATA_IN, .BUS_READY, .BUS_ADDR, .BUS_DATA_OUT,
        .BUS_WRITE, .MEMORY_REQUEST_STROBE_N, .IO_REQUEST_STROBE_N,
        .TRANSFER_END_CH0_N, .TRANSFER_END_CH1_N, .EXTERNAL_MASTER_GRANT_N,
        .DMA_OWNS_BUS, .TERMINATION_IRQ, .DMA_STATUS_RD, .BYTE_COUNT_CH0,
        .BYTE_COUNT_CH1);
    dcdma_bus_partner dcdma_bus_partner_inst (.CLOCK, .slow, .BUS_ADDR,
        .BUS_WRITE, .MEMORY_REQUEST_STROBE_N, .IO_REQUEST_STROBE_N,
        .BUS_READY, .BUS_DATA_IN);
    initial
    begin
        CLOCK = 0;
        forever #2.5 CLOCK = ~CLOCK;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // an access ends when strobe, direction or address moves on
    always @(negedge CLOCK)
    begin
        cur = {BUS_ADDR, BUS_WRITE, MEMORY_REQUEST_STROBE_N,
            IO_REQUEST_STROBE_N};
        if (!(prv[1] && prv[0]) && cur != prv && !prv[2])
        begin
            chk(!prv[0], !src_mem);
            if (src_mem)
                chk(prv[22:3], base + nread);
            q.push_back(prv[10:3] ^ 8'ha5);
            nread++;
        end
        else if (!(prv[1] && prv[0]) && cur != prv)
        begin
            chk(!prv[0], src_mem);
            chk(pdo, q.size() ? q.pop_front() : 8'h00);
            nbytes++;
            chk(pend, nbytes != n_exp);
        end
        prv = cur;
        pdo = BUS_DATA_OUT;
        pend = ch ? TRANSFER_END_CH1_N : TRANSFER_END_CH0_N;
    end
    task automatic wstat(input logic [7:0] v);
        @(negedge CLOCK);
        STATUS_WR = v;
        STATUS_WE = 1;
        @(negedge CLOCK);
        STATUS_WE = 0;
    endtask
    task automatic do_reset();
        RST = 1;
        repeat (8) @(negedge CLOCK);
        RST = 0;
    endtask
    // one channel run: program, request, interfere, then check the end
    task automatic run(input int c, s, n, sense, input bit xm, ab);
        int k;
        int per;
        logic [7:0] en;
        ch = c;
        sel = s;
        n_exp = n;
        nbytes = 0;
        nread = 0;
        q.delete();
        per = $urandom_range(9, 4);
        slow = xm | $urandom_range(1);
        src_mem = c == 1 || s == 0;
        en = c ? 8'h53 : 8'ha5;
        @(negedge CLOCK);
        DMA_WAIT_CONTROL_WR = sense ? (c ? 8'h04 : 8'h08) : 8'h00;
        CHANNEL0_MODE_WR = c ? 4'h0 : (s ? 4'h2 : 4'h8);
        SOURCE_ADDRESS_CH0 = s ? {2'h0, 2'(s), 16'h0008} : 20'h0fffe;
        DESTINATION_ADDRESS_CH0 = s ? 20'h02000 : 20'h00040;
        base = c ? MEMORY_ADDRESS_CH1 : SOURCE_ADDRESS_CH0;
        BYTE_COUNT_CH0_WR = 16'(n);
        BYTE_COUNT_CH1_WR = 16'(n);
        {WAIT_CONTROL_WE, MODE_WE, COUNT0_WE, COUNT1_WE} = {3'h7, c == 1};
        COUNT0_WE = c == 0;
        @(negedge CLOCK);
        {WAIT_CONTROL_WE, MODE_WE, COUNT0_WE, COUNT1_WE} = 4'h0;
        wstat(en);
        for (k = 0; k < 3000 && (k < 45 || en[c ? 4 : 7]); k++)
        begin
            @(negedge CLOCK);
            en[7] = DMA_STATUS_RD[7];
            en[4] = DMA_STATUS_RD[4];
            req_n = sense ? k % per < per / 2 : k >= 14 && k < 32;
            EXTERNAL_MASTER_REQUEST_N = !(xm && k >= 12 && k < 30);
            NMI_N = !(ab && k == 10);
            if (!sense && k == 31)
                chk(DMA_OWNS_BUS, 0);
            if (xm && k == 29)
                chk(EXTERNAL_MASTER_GRANT_N, 0);
            if (ab && k == 16)
                chk(DMA_STATUS_RD[0], 0);
            if (ab && k == 20)
                hold = BYTE_COUNT_CH0;
            if (ab && k == 40)
                chk(BYTE_COUNT_CH0, hold);
            if (ab && k == 41)
                wstat(c ? 8'h53 : 8'ha5);
        end
        req_n = 1;
        repeat (3) @(negedge CLOCK);
        chk(nbytes, n);
        chk(c ? BYTE_COUNT_CH1 : BYTE_COUNT_CH0, 0);
        chk(DMA_STATUS_RD[c ? 4 : 7], 0);
        chk(TERMINATION_IRQ, 1);
        wstat(8'h61);
    endtask
    initial
    begin
        {RST, req_n, NMI_N, EXTERNAL_MASTER_REQUEST_N, slow} = 5'h1f;
        {WAIT_CONTROL_WE, MODE_WE, STATUS_WE, COUNT0_WE, COUNT1_WE} = 5'h0;
        ch = 0;
        sel = 0;
        n_exp = 0;
        nbytes = 0;
        nread = 0;
        n_mismatch = 0;
        checks = 0;
        {DMA_WAIT_CONTROL_WR, STATUS_WR, CHANNEL0_MODE_WR} = 20'h0;
        {SOURCE_ADDRESS_CH0, DESTINATION_ADDRESS_CH0} = 40'h0;
        {BYTE_COUNT_CH0_WR, BYTE_COUNT_CH1_WR} = 32'h0;
        MEMORY_ADDRESS_CH1 = 20'h1fffe;
        IO_ADDRESS_CH1 = 16'h0050;
        void'($urandom(38815));
        do_reset();
        wstat(8'hc1);
        chk(DMA_STATUS_RD[7], 0);
        BYTE_COUNT_CH0_WR = 16'h0005;
        COUNT0_WE = 1;
        @(negedge CLOCK);
        COUNT0_WE = 0;
        do_reset();
        chk(BYTE_COUNT_CH0, 16'h0005);
        chk(DMA_STATUS_RD & 8'h91, 0);
        run(0, 0, 6, 0, 0, 0);
        for (int s = 1; s < 3; s++)
            run(0, s, 2, 1, 0, 0);
        run(1, 0, 5, 1, 1, 0);
        run(0, 0, 12, 0, 0, 1);
        stop_test();
    end
    initial
    begin
        #150000;
        n_mismatch++;
        stop_test();
    end
endmodule
